//--- rtcacc_assertions.sv
`timescale 1ns/1ps

module rtcacc_assertions
  import rtcacc_pkg::*;
#(
  parameter int TMO_CYCLES = RTCACC_TMO_CYCLES
) (
  input wire logic       clk_in,
  input wire logic       rst_in,
  input wire logic       link_clk_in,
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe_n_out,
  input wire logic       carry_hold_out,
  input wire logic       reg_wr_out,
  input wire logic       reg_rd_out,
  input wire logic [3:0] reg_addr_out,
  input wire logic [7:0] reg_wdata_out,
  input wire logic [7:0] reg_rdata_in
);
  logic [3:0]  last_addr_reg;
  logic        seen_reg;
  logic        late_reg;
  logic [31:0] hold_cnt_reg;

  // Last write address of this access
  always_ff @(posedge clk_in)
    if (rst_in || !carry_hold_out)
      seen_reg <= 1'b0;
    else if (reg_wr_out)
      seen_reg <= 1'b1;

  always_ff @(posedge clk_in)
    if (reg_wr_out)
      last_addr_reg <= reg_addr_out;

  // Length of the open access
  always_ff @(posedge clk_in)
    if (rst_in || !carry_hold_out)
      hold_cnt_reg <= '0;
    else
      hold_cnt_reg <= hold_cnt_reg + 32'h1;

  // Access ran long, dead until stop
  always_ff @(posedge clk_in)
    if (rst_in || ($rose(sda_in) && scl_in))
      late_reg <= 1'b0;
    else if (hold_cnt_reg > TMO_CYCLES / 2)
      late_reg <= 1'b1;

  sequence start_s;
    $fell(sda_in) && scl_in;
  endsequence

  sequence stop_s;
    $rose(sda_in) && scl_in;
  endsequence

  sda_drive_zero_a: assert property (@(posedge link_clk_in) disable iff (rst_in)
    sda_out == 1'b0) else $error("sda drive value not zero");
  oe_steady_a: assert property (@(posedge link_clk_in) disable iff (rst_in)
    scl_in && $past(scl_in) |-> $stable(sda_oe_n_out)) else $error("sda enable moved with scl high");
  hold_on_start_a: assert property (@(posedge clk_in) disable iff (rst_in)
    start_s and !late_reg |-> ##[1:40] carry_hold_out) else $error("no carry hold after start");
  release_on_stop_a: assert property (@(posedge clk_in) disable iff (rst_in)
    stop_s |-> ##[1:40] !carry_hold_out) else $error("carry hold kept after stop");
  pulse_one_a: assert property (@(posedge clk_in) disable iff (rst_in)
    reg_wr_out || reg_rd_out |=> !reg_wr_out && !reg_rd_out) else $error("register strobe too long");
  wr_in_hold_a: assert property (@(posedge clk_in) disable iff (rst_in)
    reg_wr_out |-> carry_hold_out) else $error("write outside open access");
  wr_ptr_inc_a: assert property (@(posedge clk_in) disable iff (rst_in)
    reg_wr_out && seen_reg |-> reg_addr_out == last_addr_reg + 4'h1) else $error("write address not next");
  tmo_bound_a: assert property (@(posedge clk_in) disable iff (rst_in)
    hold_cnt_reg <= TMO_CYCLES + 16) else $error("access not ended by timeout");
endmodule

bind rtcacc_top rtcacc_assertions #(.TMO_CYCLES(TMO_CYCLES)) rtcacc_assertions_inst (
  .clk_in(clk_in), .rst_in(rst_in), .link_clk_in(link_clk_in), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out), .carry_hold_out(carry_hold_out),
  .reg_wr_out(reg_wr_out), .reg_rd_out(reg_rd_out), .reg_addr_out(reg_addr_out),
  .reg_wdata_out(reg_wdata_out), .reg_rdata_in(reg_rdata_in));

//--- rtcacc_host_bfm.sv
`timescale 1ns/1ps

module rtcacc_host_bfm #(
  parameter int Q   = 10,
  parameter int GAP = 6200
) (
  input  wire logic clk_in,
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_low_out
);
  initial
  begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end

  task automatic wq();
    repeat (Q) @(posedge clk_in);
  endtask

  // Data set with scl low, sampled mid high
  task automatic bit_c(input logic drv_low, output logic smp);
    wq();
    sda_low_out <= drv_low;
    wq();
    scl_out <= 1'b1;
    wq();
    smp = sda_in;
    wq();
    scl_out <= 1'b0;
  endtask

  task automatic start_c();
    wq();
    sda_low_out <= 1'b0;
    wq();
    scl_out <= 1'b1;
    wq();
    sda_low_out <= 1'b1;
    wq();
    scl_out <= 1'b0;
  endtask

  // Stop, then quiet time before next start
  task automatic stop_c();
    wq();
    sda_low_out <= 1'b1;
    wq();
    scl_out <= 1'b1;
    wq();
    sda_low_out <= 1'b0;
    repeat (GAP) @(posedge clk_in);
  endtask

  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_c(~b[i], s);
    bit_c(1'b0, s);
    ack = ~s;
  endtask

  task automatic rd_byte(input logic give_ack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_c(1'b0, s);
      b[i] = s;
    end
    bit_c(give_ack, s);
  endtask
endmodule

//--- rtcacc_pkg.sv
package rtcacc_pkg;

  // Bus-facing constants
  localparam logic [6:0] RTCACC_SLAVE_ADDR = 7'h32;
  localparam logic [3:0] RTCACC_FMT_WRITE  = 4'h0;
  localparam logic [3:0] RTCACC_FMT_RDNOW  = 4'h4;
  localparam logic [3:0] RTCACC_PTR_REST   = 4'hf;
  localparam logic [7:0] RTCACC_DEAD_DATA  = 8'hff;
  localparam logic [3:0] RTCACC_BYTE_BITS  = 4'h8;

  // Byte position within one access
  localparam logic [1:0] RTCACC_BYTE_ADDR  = 2'h0;
  localparam logic [1:0] RTCACC_BYTE_PTR   = 2'h1;
  localparam logic [1:0] RTCACC_BYTE_DATA  = 2'h2;

  // Reset values of the link pins after filtering
  localparam logic [1:0] RTCACC_PIN_IDLE   = 2'h3;

  // Access timeout, least figure of the window, rounded up to cycles
  localparam int RTCACC_CLK_HZ     = 100000000;
  localparam int RTCACC_TMO_MS     = 500;
  localparam int RTCACC_TMO_CYCLES = RTCACC_TMO_MS * (RTCACC_CLK_HZ / 1000);

  typedef enum logic [2:0] {
    RTCACC_ST_IDLE  = 3'b000,
    RTCACC_ST_RX    = 3'b001,
    RTCACC_ST_ACK   = 3'b010,
    RTCACC_ST_TX    = 3'b011,
    RTCACC_ST_TXACK = 3'b100
  } rtcacc_state_e;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] data;
  } rtcacc_req_s;

endpackage

//--- rtcacc_sync3.sv
`timescale 1ns/1ps

module rtcacc_sync3 #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  // Three stages; a change counts once stages two and three agree
  always_ff @(posedge clk_in)
  begin
    s1_reg <= d_in;
    s2_reg <= s1_reg;
    s3_reg <= s2_reg;
  end

  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      always_ff @(posedge clk_in)
      begin
        if (rst_in)
          q_out[i] <= RST_VAL[i];
        else if (s2_reg[i] == s3_reg[i])
          q_out[i] <= s3_reg[i];
      end
    end
  endgenerate

endmodule

//--- rtcacc_top.sv
// Function
// - SDA edges while SCL high: start, stop
// - Eight-bit bytes, receiver acks on ninth clock
// - Master nack ends read; device releases SDA
// - First byte: address MSB first, then direction
// - Answer only slave address 0110010
// - Start before stop is repeated start
// - Second write byte loads pointer and format
// - Data bytes stored, pointer increments, wraps
// - Every stop sets pointer to Fh
// - Format 4h starts reading right after pointer
// - Read without pointer write starts at Fh
// - Hold carries from start until stop
// - Timeout 0.5 to 1.0 s ends access
// - Repeated start does not restart timeout
// - After timeout: no ack writes, FFh reads
`timescale 1ns/1ps

module rtcacc_top
  import rtcacc_pkg::*;
#(
  parameter int TMO_CYCLES = RTCACC_TMO_CYCLES
) (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       link_clk_in,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_n_out,
  output logic            carry_hold_out,
  output logic            reg_wr_out,
  output logic            reg_rd_out,
  output logic [3:0]      reg_addr_out,
  output logic [7:0]      reg_wdata_out,
  input  wire logic [7:0] reg_rdata_in
);

  // Link domain signals
  logic          link_rst;
  logic [1:0]    pin_q;
  logic          scl_f;
  logic          sda_f;
  logic          scl_q_reg;
  logic          sda_q_reg;
  logic          scl_rise;
  logic          scl_fall;
  logic          start_det;
  logic          stop_det;
  logic [1:0]    sys_l;
  logic          tmo_l;
  logic          rd_ack_l;
  logic          rd_ack_q_reg;
  logic          tmo_hit;
  rtcacc_state_e state_reg;
  logic [3:0]    bit_cnt_reg;
  logic [1:0]    byte_idx_reg;
  logic [7:0]    shift_reg;
  logic [7:0]    tx_reg;
  logic [3:0]    ptr_reg;
  logic          tx_next_reg;
  logic          mst_ack_reg;
  logic          acc_reg;
  logic          dead_reg;
  logic          wr_tog_reg;
  rtcacc_req_s   wr_req_reg;
  logic          rd_tog_reg;
  logic [3:0]    rd_addr_reg;
  logic [7:0]    rd_data_reg;
  logic [7:0]    tx_byte;
  logic          addr_hit;

  // System domain signals
  logic [2:0]    link_s;
  logic          acc_s;
  logic          wr_tog_s;
  logic          rd_tog_s;
  logic          wr_tog_q_reg;
  logic          rd_tog_q_reg;
  logic          rd_pend_reg;
  logic          rd_ack_tog_reg;
  logic [7:0]    rd_rsp_reg;
  logic [31:0]   tmo_cnt_reg;
  logic          tmo_reg;

  // Reset into the link domain
  rtcacc_sync3 #(
    .W       (1),
    .RST_VAL (1'b0)
  ) u_rst_sync (
    .clk_in (link_clk_in),
    .rst_in (1'b0),
    .d_in   (rst_in),
    .q_out  (link_rst)
  );

  // Bus pins into the link domain
  rtcacc_sync3 #(
    .W       (2),
    .RST_VAL (RTCACC_PIN_IDLE)
  ) u_pin_sync (
    .clk_in (link_clk_in),
    .rst_in (link_rst),
    .d_in   ({scl_in, sda_in}),
    .q_out  (pin_q)
  );

  // Timeout and read answer into the link domain
  rtcacc_sync3 #(
    .W       (2),
    .RST_VAL (2'h0)
  ) u_sys_to_link (
    .clk_in (link_clk_in),
    .rst_in (link_rst),
    .d_in   ({tmo_reg, rd_ack_tog_reg}),
    .q_out  (sys_l)
  );

  // Access level and request toggles into the system domain
  rtcacc_sync3 #(
    .W       (3),
    .RST_VAL (3'h0)
  ) u_link_to_sys (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .d_in   ({acc_reg, wr_tog_reg, rd_tog_reg}),
    .q_out  (link_s)
  );

  assign scl_f    = pin_q[1];
  assign sda_f    = pin_q[0];
  assign tmo_l    = sys_l[1];
  assign rd_ack_l = sys_l[0];
  assign acc_s    = link_s[2];
  assign wr_tog_s = link_s[1];
  assign rd_tog_s = link_s[0];

  // Bus conditions
  assign scl_rise  = scl_f & ~scl_q_reg;
  assign scl_fall  = ~scl_f & scl_q_reg;
  assign start_det = scl_f & scl_q_reg & sda_q_reg & ~sda_f;
  assign stop_det  = scl_f & scl_q_reg & ~sda_q_reg & sda_f;
  assign tmo_hit   = tmo_l & acc_reg;
  assign addr_hit  = shift_reg[7:1] == RTCACC_SLAVE_ADDR;
  assign tx_byte   = dead_reg ? RTCACC_DEAD_DATA : rd_data_reg;

  always_ff @(posedge link_clk_in)
  begin
    if (link_rst)
    begin
      scl_q_reg <= 1'b1;
      sda_q_reg <= 1'b1;
    end
    else
    begin
      scl_q_reg <= scl_f;
      sda_q_reg <= sda_f;
    end
  end

  // Open access level; a repeated start leaves it standing
  always_ff @(posedge link_clk_in)
  begin
    if (link_rst)
    begin
      acc_reg  <= 1'b0;
      dead_reg <= 1'b0;
    end
    else if (stop_det)
    begin
      acc_reg  <= 1'b0;
      dead_reg <= 1'b0;
    end
    else if (start_det && !dead_reg)
      acc_reg <= 1'b1;
    else if (tmo_hit)
    begin
      acc_reg  <= 1'b0;
      dead_reg <= 1'b1;
    end
  end

  // Read data returned from the system side
  always_ff @(posedge link_clk_in)
  begin
    if (link_rst)
    begin
      rd_ack_q_reg <= 1'b0;
      rd_data_reg  <= RTCACC_DEAD_DATA;
    end
    else
    begin
      rd_ack_q_reg <= rd_ack_l;
      if (rd_ack_l != rd_ack_q_reg)
        rd_data_reg <= rd_rsp_reg;
    end
  end

  // Byte engine
  always_ff @(posedge link_clk_in)
  begin
    if (link_rst)
    begin
      state_reg    <= RTCACC_ST_IDLE;
      bit_cnt_reg  <= 4'h0;
      byte_idx_reg <= RTCACC_BYTE_ADDR;
      shift_reg    <= 8'h00;
      tx_reg       <= 8'h00;
      ptr_reg      <= RTCACC_PTR_REST;
      tx_next_reg  <= 1'b0;
      mst_ack_reg  <= 1'b0;
      sda_oe_n_out <= 1'b1;
      wr_tog_reg   <= 1'b0;
      wr_req_reg   <= '0;
      rd_tog_reg   <= 1'b0;
      rd_addr_reg  <= RTCACC_PTR_REST;
    end
    else if (stop_det)
    begin
      state_reg    <= RTCACC_ST_IDLE;
      sda_oe_n_out <= 1'b1;
      ptr_reg      <= RTCACC_PTR_REST;
    end
    else if (start_det)
    begin
      state_reg    <= RTCACC_ST_RX;
      bit_cnt_reg  <= 4'h0;
      byte_idx_reg <= RTCACC_BYTE_ADDR;
      sda_oe_n_out <= 1'b1;
    end
    else
    begin
      if (tmo_hit)
        ptr_reg <= RTCACC_PTR_REST;
      case (state_reg)
        RTCACC_ST_IDLE:
        begin
          sda_oe_n_out <= 1'b1;
        end
        RTCACC_ST_RX:
        begin
          if (scl_rise)
          begin
            shift_reg   <= {shift_reg[6:0], sda_f};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
          else if (scl_fall && bit_cnt_reg == RTCACC_BYTE_BITS)
          begin
            bit_cnt_reg <= 4'h0;
            tx_next_reg <= 1'b0;
            case (byte_idx_reg)
              RTCACC_BYTE_ADDR:
              begin
                if (addr_hit && (!dead_reg || shift_reg[0]))
                begin
                  state_reg    <= RTCACC_ST_ACK;
                  sda_oe_n_out <= 1'b0;
                  tx_next_reg  <= shift_reg[0];
                  byte_idx_reg <= RTCACC_BYTE_PTR;
                  if (shift_reg[0])
                  begin
                    rd_addr_reg <= ptr_reg;
                    rd_tog_reg  <= ~rd_tog_reg;
                  end
                end
                else
                  state_reg <= RTCACC_ST_IDLE;
              end
              RTCACC_BYTE_PTR:
              begin
                if (dead_reg)
                  state_reg <= RTCACC_ST_IDLE;
                else
                begin
                  state_reg    <= RTCACC_ST_ACK;
                  sda_oe_n_out <= 1'b0;
                  ptr_reg      <= shift_reg[7:4];
                  byte_idx_reg <= RTCACC_BYTE_DATA;
                  if (shift_reg[3:0] == RTCACC_FMT_RDNOW)
                  begin
                    tx_next_reg <= 1'b1;
                    rd_addr_reg <= shift_reg[7:4];
                    rd_tog_reg  <= ~rd_tog_reg;
                  end
                end
              end
              default:
              begin
                if (dead_reg)
                  state_reg <= RTCACC_ST_IDLE;
                else
                begin
                  state_reg       <= RTCACC_ST_ACK;
                  sda_oe_n_out    <= 1'b0;
                  wr_req_reg.addr <= ptr_reg;
                  wr_req_reg.data <= shift_reg;
                  wr_tog_reg      <= ~wr_tog_reg;
                  ptr_reg         <= ptr_reg + 4'h1;
                end
              end
            endcase
          end
        end
        RTCACC_ST_ACK:
        begin
          if (scl_fall)
          begin
            if (tx_next_reg)
            begin
              state_reg    <= RTCACC_ST_TX;
              sda_oe_n_out <= tx_byte[7];
              tx_reg       <= {tx_byte[6:0], 1'b0};
              bit_cnt_reg  <= 4'h1;
            end
            else
            begin
              state_reg    <= RTCACC_ST_RX;
              sda_oe_n_out <= 1'b1;
              bit_cnt_reg  <= 4'h0;
            end
          end
        end
        RTCACC_ST_TX:
        begin
          if (scl_fall)
          begin
            if (bit_cnt_reg == RTCACC_BYTE_BITS)
            begin
              state_reg    <= RTCACC_ST_TXACK;
              sda_oe_n_out <= 1'b1;
            end
            else
            begin
              sda_oe_n_out <= tx_reg[7];
              tx_reg       <= {tx_reg[6:0], 1'b0};
              bit_cnt_reg  <= bit_cnt_reg + 4'h1;
            end
          end
        end
        RTCACC_ST_TXACK:
        begin
          if (scl_rise)
          begin
            mst_ack_reg <= ~sda_f;
            if (!sda_f)
            begin
              ptr_reg     <= ptr_reg + 4'h1;
              rd_addr_reg <= ptr_reg + 4'h1;
              rd_tog_reg  <= ~rd_tog_reg;
            end
          end
          else if (scl_fall)
          begin
            if (mst_ack_reg)
            begin
              state_reg    <= RTCACC_ST_TX;
              sda_oe_n_out <= tx_byte[7];
              tx_reg       <= {tx_byte[6:0], 1'b0};
              bit_cnt_reg  <= 4'h1;
            end
            else
            begin
              state_reg    <= RTCACC_ST_IDLE;
              sda_oe_n_out <= 1'b1;
            end
          end
        end
        default:
        begin
          state_reg    <= RTCACC_ST_IDLE;
          sda_oe_n_out <= 1'b1;
        end
      endcase
    end
  end

  // Open-drain data low level
  always_ff @(posedge link_clk_in)
  begin
    sda_out <= 1'b0;
  end

  // Register path toward the time counters
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      wr_tog_q_reg   <= 1'b0;
      rd_tog_q_reg   <= 1'b0;
      reg_wr_out     <= 1'b0;
      reg_rd_out     <= 1'b0;
      reg_addr_out   <= RTCACC_PTR_REST;
      reg_wdata_out  <= 8'h00;
      rd_pend_reg    <= 1'b0;
    end
    else
    begin
      wr_tog_q_reg <= wr_tog_s;
      rd_tog_q_reg <= rd_tog_s;
      reg_wr_out   <= wr_tog_s != wr_tog_q_reg;
      reg_rd_out   <= rd_tog_s != rd_tog_q_reg;
      rd_pend_reg  <= rd_tog_s != rd_tog_q_reg;
      if (wr_tog_s != wr_tog_q_reg)
      begin
        reg_addr_out  <= wr_req_reg.addr;
        reg_wdata_out <= wr_req_reg.data;
      end
      else if (rd_tog_s != rd_tog_q_reg)
        reg_addr_out <= rd_addr_reg;
    end
  end

  // Read answer back to the link
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      rd_ack_tog_reg <= 1'b0;
      rd_rsp_reg     <= RTCACC_DEAD_DATA;
    end
    else if (rd_pend_reg)
    begin
      rd_rsp_reg     <= reg_rdata_in;
      rd_ack_tog_reg <= ~rd_ack_tog_reg;
    end
  end

  // Access timeout from the first start
  always_ff @(posedge clk_in)
  begin
    if (rst_in || !acc_s)
    begin
      tmo_cnt_reg <= 32'h0;
      tmo_reg     <= 1'b0;
    end
    else if (tmo_cnt_reg == 32'(TMO_CYCLES - 1))
      tmo_reg <= 1'b1;
    else
      tmo_cnt_reg <= tmo_cnt_reg + 32'h1;
  end

  // Carry hold for the time counters
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      carry_hold_out <= 1'b0;
    else
      carry_hold_out <= acc_s & ~tmo_reg;
  end

endmodule

//--- tb_top.sv
`timescale 1ns/1ps

module tb_top;
  localparam logic [7:0] WR = {7'b0110010, 1'b0};
  localparam logic [7:0] RD = {7'b0110010, 1'b1};

  logic       clk;
  logic       rst;
  logic       link_clk;
  logic       scl;
  logic       sda_low;
  logic       sda_out;
  logic       sda_oe_n;
  logic       hold;
  logic       wr;
  logic       rd;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  wire        sda;
  logic [7:0] mem [16];
  int         miscompares;
  int         tests_run;
  int         cycles;

  assign sda = ~(sda_low | (~sda_oe_n & ~sda_out));
  assign rdata = mem[addr];

  always #5 clk = ~clk;

  initial
  begin
    link_clk = 1'b0;
    #1.7;
    forever #3 link_clk = ~link_clk;
  end

  always @(posedge clk)
    if (wr)
      mem[addr] <= wdata;

  rtcacc_top #(.TMO_CYCLES(3000)) rtcacc_top_inst (
    .clk_in(clk), .rst_in(rst), .link_clk_in(link_clk), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_n_out(sda_oe_n), .carry_hold_out(hold), .reg_wr_out(wr),
    .reg_rd_out(rd), .reg_addr_out(addr), .reg_wdata_out(wdata), .reg_rdata_in(rdata));

  rtcacc_host_bfm rtcacc_host_bfm_inst (.clk_in(clk), .sda_in(sda), .scl_out(scl), .sda_low_out(sda_low));

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run = tests_run + 1;
    if (seen !== exp)
    begin
      miscompares = miscompares + 1;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wb(input logic [7:0] b, input logic e);
    logic a;
    rtcacc_host_bfm_inst.wr_byte(b, a);
    check({7'h0, a}, {7'h0, e});
  endtask

  task automatic rb(input logic give_ack, input logic [7:0] e);
    logic [7:0] d;
    rtcacc_host_bfm_inst.rd_byte(give_ack, d);
    check(d, e);
  endtask

  task automatic t_write();
    rtcacc_host_bfm_inst.start_c();
    wb(WR, 1'b1);
    wb(8'hf0, 1'b1);
    wb(8'ha1, 1'b1);
    wb(8'hb2, 1'b1);
    check({7'h0, hold}, 8'h01);
    rtcacc_host_bfm_inst.stop_c();
    check({7'h0, hold}, 8'h00);
    check(mem[4'hf], 8'ha1);
    check(mem[4'h0], 8'hb2);
  endtask

  task automatic t_read_ptr();
    rtcacc_host_bfm_inst.start_c();
    wb(WR, 1'b1);
    wb(8'h20, 1'b1);
    rtcacc_host_bfm_inst.start_c();
    wb(RD, 1'b1);
    rb(1'b1, 8'h42);
    rb(1'b1, 8'h43);
    rb(1'b0, 8'h44);
    rtcacc_host_bfm_inst.stop_c();
    check({7'h0, hold}, 8'h00);
  endtask

  task automatic t_read_now();
    rtcacc_host_bfm_inst.start_c();
    wb(WR, 1'b1);
    wb(8'he4, 1'b1);
    rb(1'b1, 8'h4e);
    rb(1'b1, 8'ha1);
    rb(1'b0, 8'hb2);
    rtcacc_host_bfm_inst.stop_c();
  endtask

  task automatic t_read_rest();
    rtcacc_host_bfm_inst.start_c();
    wb(RD, 1'b1);
    rb(1'b1, 8'ha1);
    rb(1'b0, 8'hb2);
    rtcacc_host_bfm_inst.stop_c();
  endtask

  task automatic t_bad_addr();
    rtcacc_host_bfm_inst.start_c();
    wb({7'b0110011, 1'b0}, 1'b0);
    wb(8'hf0, 1'b0);
    rtcacc_host_bfm_inst.stop_c();
  endtask

  task automatic t_timeout();
    rtcacc_host_bfm_inst.start_c();
    wb(WR, 1'b1);
    repeat (900) @(posedge clk);
    rtcacc_host_bfm_inst.start_c();
    wb(WR, 1'b1);
    check({7'h0, hold}, 8'h01);
    repeat (1900) @(posedge clk);
    check({7'h0, hold}, 8'h00);
    wb(8'h00, 1'b0);
    rtcacc_host_bfm_inst.start_c();
    wb(RD, 1'b1);
    rb(1'b0, 8'hff);
    rtcacc_host_bfm_inst.stop_c();
  endtask

  always @(posedge clk)
  begin
    cycles = cycles + 1;
    if (cycles == 90000)
    begin
      miscompares = miscompares + 1;
      tally_and_finish();
    end
  end

  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    miscompares = 0;
    tests_run = 0;
    cycles = 0;
    for (int i = 0; i < 16; i++)
      mem[i] = 8'h40 + 8'(i);
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (20) @(posedge clk);
    t_write();
    t_read_ptr();
    t_read_now();
    t_read_rest();
    t_bad_addr();
    t_timeout();
    tally_and_finish();
  end
endmodule
